// >>> src/hcr_result_bank.sv
// Read-only hit-count result bank: latches two 32-bit hit sums per measurement.
// Assumes the host register interface gives one-cycle read/write strobes on i_clock.
//
// Contract
// - Reference hit sum at 0x33..0x36, lowest byte at lowest address.
// - Object hit sum at 0x37..0x3A, lowest byte at lowest address.
// - Reference sum reads zero without object or without distance algorithm.
// - Object sum reads zero without object or without distance algorithm.
`timescale 1ns/100ps
`default_nettype none
module hcr_result_bank (
    input  wire logic                 i_clock,
    input  wire logic                 i_srst,
    input  wire logic                 i_result_valid,
    input  wire hcr_pkg::hcr_result_t i_result,
    input  wire hcr_pkg::hcr_read_t   i_read,
    input  wire logic                 i_wr,
    input  wire logic [7:0]           i_wr_addr,
    input  wire logic [7:0]           i_wr_data,
    output logic                      o_rd_hit,
    output logic [7:0]                o_rd_data
);
    logic [31:0] ref_sum;
    logic [31:0] target_sum;
    logic [31:0] next_ref_sum;
    logic [31:0] next_target_sum;
    logic        next_rd_hit;
    logic [7:0]  next_rd_data;
    logic        result_ok;
    logic        ref_hit;
    logic        tgt_hit;
    logic [7:0]  ref_byte;
    logic [7:0]  tgt_byte;

    // Write port exists only so writes land somewhere harmless
    logic        unused_wr;
    assign unused_wr = i_wr ^ (^i_wr_addr) ^ (^i_wr_data);

    assign result_ok = i_result.object_found && i_result.distance_algo;

    // Sum registers: load on each finished measurement, hold otherwise
    always_comb begin
        next_ref_sum    = ref_sum;
        next_target_sum = target_sum;
        if (i_result_valid) begin
            next_ref_sum    = result_ok ? i_result.ref_sum : hcr_pkg::SUM_RESET;
            next_target_sum = result_ok ? i_result.target_sum : hcr_pkg::SUM_RESET;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ref_sum    <= hcr_pkg::SUM_RESET;
            target_sum <= hcr_pkg::SUM_RESET;
        end else begin
            ref_sum    <= next_ref_sum;
            target_sum <= next_target_sum;
        end
    end

    hcr_byte_mux #(.BASE(hcr_pkg::REF_BYTE0)) u_ref_mux (
        .i_sum  (ref_sum),
        .i_addr (i_read.addr),
        .o_hit  (ref_hit),
        .o_byte (ref_byte)
    );

    hcr_byte_mux #(.BASE(hcr_pkg::TGT_BYTE0)) u_tgt_mux (
        .i_sum  (target_sum),
        .i_addr (i_read.addr),
        .o_hit  (tgt_hit),
        .o_byte (tgt_byte)
    );

    // Read path: one registered answer per read strobe
    always_comb begin
        next_rd_hit  = 1'b0;
        next_rd_data = hcr_pkg::READ_ZERO;
        if (i_read.rd) begin
            next_rd_hit = ref_hit || tgt_hit;
            if (ref_hit) begin
                next_rd_data = ref_byte;
            end else if (tgt_hit) begin
                next_rd_data = tgt_byte;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rd_hit  <= 1'b0;
            o_rd_data <= hcr_pkg::READ_ZERO;
        end else begin
            o_rd_hit  <= next_rd_hit;
            o_rd_data <= next_rd_data;
        end
    end

    property p_ref_byte0;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::REF_BYTE0
            |=> o_rd_hit && o_rd_data == $past(ref_sum[7:0]);
    endproperty
    a_ref_byte0: assert property (p_ref_byte0) else $error("ref byte0 wrong");

    property p_ref_byte3;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::REF_BYTE3
            |=> o_rd_hit && o_rd_data == $past(ref_sum[31:24]);
    endproperty
    a_ref_byte3: assert property (p_ref_byte3) else $error("ref byte3 wrong");

    property p_tgt_byte0;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::TGT_BYTE0
            |=> o_rd_hit && o_rd_data == $past(target_sum[7:0]);
    endproperty
    a_tgt_byte0: assert property (p_tgt_byte0) else $error("target byte0 wrong");

    property p_tgt_byte3;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::TGT_BYTE3
            |=> o_rd_hit && o_rd_data == $past(target_sum[31:24]);
    endproperty
    a_tgt_byte3: assert property (p_tgt_byte3) else $error("target byte3 wrong");

    property p_ref_zero;
        @(posedge i_clock) disable iff (i_srst)
        i_result_valid && !(i_result.object_found && i_result.distance_algo)
            |=> ref_sum == 32'h0000_0000;
    endproperty
    a_ref_zero: assert property (p_ref_zero) else $error("ref sum not cleared");

    property p_tgt_zero;
        @(posedge i_clock) disable iff (i_srst)
        i_result_valid && !(i_result.object_found && i_result.distance_algo)
            |=> target_sum == 32'h0000_0000;
    endproperty
    a_tgt_zero: assert property (p_tgt_zero) else $error("target sum not cleared");

    property p_hold;
        @(posedge i_clock) disable iff (i_srst)
        !i_result_valid |=> $stable(ref_sum) && $stable(target_sum);
    endproperty
    a_hold: assert property (p_hold) else $error("sums changed without measurement");

    property p_reset_zero;
        @(posedge i_clock) i_srst |=> ref_sum == 32'h0000_0000 && target_sum == 32'h0000_0000;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("sums not zero after reset");

    property p_load;
        @(posedge i_clock) disable iff (i_srst)
        i_result_valid && i_result.object_found && i_result.distance_algo
            |=> ref_sum == $past(i_result.ref_sum) && target_sum == $past(i_result.target_sum);
    endproperty
    a_load: assert property (p_load) else $error("sums not loaded");

    // Middle bytes of both sums
    property p_ref_byte1;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::REF_BYTE1
            |=> o_rd_hit && o_rd_data == $past(ref_sum[15:8]);
    endproperty
    a_ref_byte1: assert property (p_ref_byte1) else $error("ref byte1 wrong");

    property p_ref_byte2;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::REF_BYTE2
            |=> o_rd_hit && o_rd_data == $past(ref_sum[23:16]);
    endproperty
    a_ref_byte2: assert property (p_ref_byte2) else $error("ref byte2 wrong");

    property p_tgt_byte1;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::TGT_BYTE1
            |=> o_rd_hit && o_rd_data == $past(target_sum[15:8]);
    endproperty
    a_tgt_byte1: assert property (p_tgt_byte1) else $error("target byte1 wrong");

    property p_tgt_byte2;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr == hcr_pkg::TGT_BYTE2
            |=> o_rd_hit && o_rd_data == $past(target_sum[23:16]);
    endproperty
    a_tgt_byte2: assert property (p_tgt_byte2) else $error("target byte2 wrong");

    // Reads outside the bank answer nothing
    property p_rd_miss;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && (i_read.addr < hcr_pkg::REF_BYTE0 || i_read.addr > hcr_pkg::TGT_BYTE3)
            |=> !o_rd_hit && o_rd_data == hcr_pkg::READ_ZERO;
    endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("stray read answered");

    // Answer stands one cycle only
    property p_rd_idle;
        @(posedge i_clock) disable iff (i_srst)
        !i_read.rd |=> !o_rd_hit && o_rd_data == hcr_pkg::READ_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("answer without read");

    // Every bank address reports a hit
    property p_ref_range_hit;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr >= hcr_pkg::REF_BYTE0 && i_read.addr <= hcr_pkg::REF_BYTE3
            |=> o_rd_hit;
    endproperty
    a_ref_range_hit: assert property (p_ref_range_hit) else $error("ref read missed");

    property p_tgt_range_hit;
        @(posedge i_clock) disable iff (i_srst)
        i_read.rd && i_read.addr >= hcr_pkg::TGT_BYTE0 && i_read.addr <= hcr_pkg::TGT_BYTE3
            |=> o_rd_hit;
    endproperty
    a_tgt_range_hit: assert property (p_tgt_range_hit) else $error("target read missed");

    property p_wr_ignored;
        @(posedge i_clock) disable iff (i_srst)
        i_wr && !i_result_valid |=> $stable(ref_sum) && $stable(target_sum);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("write changed a sum");

    property p_reset_out;
        @(posedge i_clock) i_srst |=> !o_rd_hit && o_rd_data == hcr_pkg::READ_ZERO;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("answer not idle after reset");

    c_valid_load: cover property (@(posedge i_clock) i_result_valid && result_ok);
    c_zero_load:  cover property (@(posedge i_clock) i_result_valid && !result_ok);
    c_read_ref:   cover property (@(posedge i_clock) i_read.rd && ref_hit);
    c_read_tgt:   cover property (@(posedge i_clock) i_read.rd && tgt_hit);
    c_wr_drop:    cover property (@(posedge i_clock) i_wr && !i_result_valid);
endmodule
`default_nettype wire

// >>> src/hcr_pkg.sv
// Package for the hit-count result bank: register offsets, widths, reset values and carriers.
// Assumes an 8-bit register address from the sensor's host register interface.
package hcr_pkg;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned SUM_W      = 32;
    localparam int unsigned SUM_BYTES  = 4;
    localparam logic [7:0]  REF_BYTE0  = 8'h33;
    localparam logic [7:0]  REF_BYTE1  = 8'h34;
    localparam logic [7:0]  REF_BYTE2  = 8'h35;
    localparam logic [7:0]  REF_BYTE3  = 8'h36;
    localparam logic [7:0]  TGT_BYTE0  = 8'h37;
    localparam logic [7:0]  TGT_BYTE1  = 8'h38;
    localparam logic [7:0]  TGT_BYTE2  = 8'h39;
    localparam logic [7:0]  TGT_BYTE3  = 8'h3A;
    localparam logic [31:0] SUM_RESET  = 32'h0000_0000;
    localparam logic [7:0]  READ_ZERO  = 8'h00;

    // One finished measurement as handed over by the distance engine
    typedef struct packed {
        logic        object_found;
        logic        distance_algo;
        logic [31:0] ref_sum;
        logic [31:0] target_sum;
    } hcr_result_t;

    // Register read request from the host interface
    typedef struct packed {
        logic       rd;
        logic [7:0] addr;
    } hcr_read_t;
endpackage

// >>> src/hcr_byte_mux.sv
// Byte selector: picks one byte of a 32-bit sum, least significant byte at the base offset.
// Assumes a combinational use inside the result bank's read path.
`timescale 1ns/100ps
`default_nettype none
module hcr_byte_mux #(
    parameter logic [7:0] BASE = 8'h00
) (
    input  wire logic [31:0] i_sum,
    input  wire logic [7:0]  i_addr,
    output logic             o_hit,
    output logic [7:0]       o_byte
);
    logic [7:0] offset;

    always_comb begin
        offset = i_addr - BASE;
        o_hit  = (i_addr >= BASE) && (offset < 8'h04);
        o_byte = 8'h00;
        if (o_hit) begin
            o_byte = i_sum[{offset[1:0], 3'b000} +: 8];
        end
    end
endmodule
`default_nettype wire

// >>> tb/hcr_host_model.sv
// Host model: issues register reads and writes on the result bank's strobes.
// Assumes strobes are taken on the rising edge of i_clock.
`timescale 1ns/100ps
`default_nettype none
module hcr_host_model (
    input  wire logic          i_clock,
    input  wire logic          i_rd_hit,
    input  wire logic [7:0]    i_rd_data,
    output var hcr_pkg::hcr_read_t o_read,
    output logic               o_wr,
    output logic [7:0]         o_wr_addr,
    output logic [7:0]         o_wr_data
);
    initial begin
        o_read = '0;
        o_wr = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // Called just after a rising edge; the released address shows its inverse
    task automatic read_reg(input logic [7:0] addr, output logic hit, output logic [7:0] data);
        o_read <= '{rd: 1'b1, addr: addr};
        @(posedge i_clock);
        o_read <= '{rd: 1'b0, addr: ~addr};
        #1;
        hit = i_rd_hit;
        data = i_rd_data;
        @(posedge i_clock);
    endtask
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        o_wr <= 1'b1;
        o_wr_addr <= addr;
        o_wr_data <= data;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_wr_addr <= ~addr;
        o_wr_data <= ~data;
    endtask
endmodule
`default_nettype wire

// >>> tb/hcr_result_bank_bench.sv
// Bench for the hit-count result bank: random measurements, stray writes, full read sweeps.
// Assumes a host model on the read and write strobes.
`timescale 1ns/100ps
`default_nettype none
module hcr_result_bank_bench;
    logic                 clock = 1'b0;
    logic                 srst = 1'b1;
    logic                 valid = 1'b0;
    hcr_pkg::hcr_result_t result = '0;
    hcr_pkg::hcr_read_t   rd_req;
    logic                 wr, rd_hit;
    logic [7:0]           wr_addr, wr_data, rd_data;
    logic [31:0]          ref_sum = 32'h0, tgt_sum = 32'h0;
    int                   miscompares = 0, num_checks = 0;

    hcr_result_bank u_dut (.i_clock(clock), .i_srst(srst), .i_result_valid(valid),
        .i_result(result), .i_read(rd_req), .i_wr(wr), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .o_rd_hit(rd_hit), .o_rd_data(rd_data));
    hcr_host_model u_host (.i_clock(clock), .i_rd_hit(rd_hit), .i_rd_data(rd_data),
        .o_read(rd_req), .o_wr(wr), .o_wr_addr(wr_addr), .o_wr_data(wr_data));

    initial begin
        forever #25 clock = ~clock;
    end
    function automatic logic [8:0] expect_read(input logic [7:0] a);
        if (a >= hcr_pkg::REF_BYTE0 && a <= hcr_pkg::REF_BYTE3) begin
            return {1'b1, ref_sum[8 * int'(a - hcr_pkg::REF_BYTE0) +: 8]};
        end
        if (a >= hcr_pkg::TGT_BYTE0 && a <= hcr_pkg::TGT_BYTE3) begin
            return {1'b1, tgt_sum[8 * int'(a - hcr_pkg::TGT_BYTE0) +: 8]};
        end
        return 9'h000;
    endfunction
    task automatic give_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Reads every bank byte plus the unmapped neighbours on both sides
    task automatic sweep();
        logic       hit;
        logic [7:0] data;
        for (int a = 8'h31; a <= 8'h3C; a++) begin
            u_host.read_reg(8'(a), hit, data);
            num_checks++;
            if ({hit, data} !== expect_read(8'(a))) begin
                miscompares++;
                $display("unexpected read %h expected %h seen %h", a, expect_read(8'(a)),
                    {hit, data});
            end
        end
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
    initial begin
        hcr_pkg::hcr_result_t r;
        void'($urandom(32'h8F8E773E));
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        sweep();
        for (int n = 0; n < 24; n++) begin
            r.ref_sum = $urandom;
            r.target_sum = $urandom;
            {r.object_found, r.distance_algo} = 2'(n) | {2{n[2]}};
            valid <= 1'b1;
            result <= r;
            @(posedge clock);
            valid <= 1'b0;
            result <= ~r;
            ref_sum = (r.object_found && r.distance_algo) ? r.ref_sum : 32'h0;
            tgt_sum = (r.object_found && r.distance_algo) ? r.target_sum : 32'h0;
            u_host.write_reg(8'($urandom_range(8'h3A, 8'h33)), 8'($urandom));
            sweep();
        end
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        ref_sum = 32'h0;
        tgt_sum = 32'h0;
        @(posedge clock);
        sweep();
        give_verdict();
    end
endmodule
`default_nettype wire
